// [include/rtc_alarm_pkg.sv]
// constants for the alarm/watchdog interrupt control block
// assumes a 100 MHz system clock and a byte-wide register bus
package rtc_alarm_pkg;
  // register addresses on the byte-wide bus
  localparam logic [5:0] ADDR_ALARM_MIN = 6'h03;
  localparam logic [5:0] ADDR_ALARM_HOUR = 6'h05;
  localparam logic [5:0] ADDR_ALARM_DAY = 6'h07;
  localparam logic [5:0] ADDR_CMD = 6'h0B;
  localparam logic [5:0] ADDR_WD_LO = 6'h0C;
  localparam logic [5:0] ADDR_WD_HI = 6'h0D;
  // command register field positions
  localparam int BIT_TRANSFER_GATE = 7;
  localparam int BIT_ROUTE_SWAP = 6;
  localparam int BIT_B_POLARITY = 5;
  localparam int BIT_PULSE_SELECT = 4;
  localparam int BIT_WD_MASK = 3;
  localparam int BIT_TOD_MASK = 2;
  localparam int BIT_WD_FLAG = 1;
  localparam int BIT_TOD_FLAG = 0;
  // alarm registers: mask in msb, day register keeps bits 7 and 2..0
  localparam int ALARM_MASK_BIT = 7;
  localparam logic [7:0] DAY_ALARM_KEEP = 8'h87;
  // reset values of the writable storage and the watchdog count limits
  localparam logic [5:0] CMD_CTRL_RESET = 6'h00;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [7:0] WD_RESET = 8'h00;
  localparam logic [15:0] WD_DISABLED = 16'h0000;
  localparam logic [15:0] WD_LAST = 16'h0001;
  // interrupt pulse width, least time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_MIN_MS = 3;
  localparam int PULSE_CYCLES =
    (PULSE_MIN_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 20;
  // bus access sequencer
  typedef enum logic [1:0] {BUS_IDLE, BUS_READ, BUS_WRITE} bus_state_type;
endpackage : rtc_alarm_pkg

// [hw/irq_pulse_timer.sv]
// one-shot timer that stretches an interrupt event into a timed pulse
// assumes start is a one-cycle pulse on clk; length fixed per instance
`timescale 1ns/1ps
`default_nettype none
module irq_pulse_timer #(
  parameter int CNT_W = rtc_alarm_pkg::PULSE_CNT_W,
  parameter logic [rtc_alarm_pkg::PULSE_CNT_W-1:0] LENGTH =
    rtc_alarm_pkg::PULSE_CNT_W'(rtc_alarm_pkg::PULSE_CYCLES)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  output logic active,
  output logic done
);
  import rtc_alarm_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic active_q;

  // count down while the pulse stands; a new start restarts it
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_q <= '0;
      active_q <= 1'b0;
    end else if (start) begin
      cnt_q <= LENGTH[CNT_W-1:0];
      active_q <= 1'b1;
    end else if (active_q) begin
      cnt_q <= cnt_q - 1'b1;
      if (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
        active_q <= 1'b0;
      end
    end
  end

  assign active = active_q;
  assign done = active_q && !start && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

  // pulse stands at least eight cycles once begun (length is larger)
  a_pulse_min_len: assert property (@(posedge clk) disable iff (reset)
    start |=> active [*8])
    else $error("interrupt pulse ended too early");
endmodule : irq_pulse_timer
`default_nettype wire

// [hw/rtc_alarm_interrupt_control.sv]
// command register, alarm flags, watchdog countdown and interrupt lines
// assumes the time counters run on clk and give one-cycle tick strobes;
// bus pins are asynchronous and are synchronised here
`timescale 1ns/1ps
`default_nettype none
module rtc_alarm_interrupt_control #(
  parameter logic [rtc_alarm_pkg::PULSE_CNT_W-1:0] PULSE_LEN =
    rtc_alarm_pkg::PULSE_CNT_W'(rtc_alarm_pkg::PULSE_CYCLES)
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe,
  input wire logic tick_100hz,
  input wire logic minute_rollover,
  input wire logic [7:0] cur_minutes,
  input wire logic [7:0] cur_hours,
  input wire logic [7:0] cur_day,
  output logic time_copy_strobe,
  output logic irq_line_a_n,
  output logic irq_line_b
);
  import rtc_alarm_pkg::*;

  // index 0 is the clock alarm, index 1 the watchdog
  localparam int SRC_TOD = 0;
  localparam int SRC_WD = 1;

  // one BCD digit step down, used for all four watchdog digits
  function automatic logic [3:0] bcd_digit_dec(input logic [3:0] d);
    bcd_digit_dec = (d == 4'h0) ? 4'h9 : d - 4'h1;
  endfunction : bcd_digit_dec

  // alarm and watchdog register decode, shared by read and write paths
  function automatic logic is_tod_alarm(input logic [5:0] a);
    is_tod_alarm = (a == ADDR_ALARM_MIN) || (a == ADDR_ALARM_HOUR) ||
                   (a == ADDR_ALARM_DAY);
  endfunction : is_tod_alarm
  function automatic logic is_wd_reg(input logic [5:0] a);
    is_wd_reg = (a == ADDR_WD_LO) || (a == ADDR_WD_HI);
  endfunction : is_wd_reg

  logic [1:0] ce_sync_q, oe_sync_q, we_sync_q;
  logic [5:0] addr_s1_q, addr_s2_q;
  logic [7:0] din_s1_q, din_s2_q;
  bus_state_type bus_q;
  logic [5:0] acc_addr_q;
  logic [7:0] wr_data_q;
  logic [7:0] rd_data_q;
  logic [5:0] ctrl_q;
  logic [7:0] alarm_min_q, alarm_hour_q, alarm_day_q;
  logic [7:0] wd_lo_q, wd_hi_q;
  logic [15:0] wd_cnt_q, wd_cnt_dec;
  logic wd_reload_q;
  logic [1:0] flag_q, set_ev, clr_ev, mask, pulse_start, pulse_act;
  logic [1:0] pulse_done, src_act;
  logic sel_acc, sel_read, sel_write, rd_start, wr_commit;
  logic tod_reg, wd_reg, tod_match;
  logic tod_acc, wd_acc;
  logic a_act, b_act;

  // two flip-flops on every bus pin before any logic looks at it
  always_ff @(posedge clk) begin
    if (reset) begin
      ce_sync_q <= 2'h3;
      oe_sync_q <= 2'h3;
      we_sync_q <= 2'h3;
      addr_s1_q <= 6'h00;
      addr_s2_q <= 6'h00;
      din_s1_q <= 8'h00;
      din_s2_q <= 8'h00;
    end else begin
      ce_sync_q <= {ce_sync_q[0], ce_n};
      oe_sync_q <= {oe_sync_q[0], oe_n};
      we_sync_q <= {we_sync_q[0], we_n};
      addr_s1_q <= addr;
      addr_s2_q <= addr_s1_q;
      din_s1_q <= dq_in;
      din_s2_q <= din_s1_q;
    end
  end

  assign sel_acc = !ce_sync_q[1];
  assign sel_read = sel_acc && we_sync_q[1];
  assign sel_write = sel_acc && !we_sync_q[1];

  // bus sequencer: a read starts on select, a write commits on release
  always_ff @(posedge clk) begin
    if (reset) begin
      bus_q <= BUS_IDLE;
      acc_addr_q <= 6'h00;
      wr_data_q <= 8'h00;
    end else begin
      unique case (bus_q)
        BUS_IDLE: begin
          acc_addr_q <= addr_s2_q;
          if (sel_write) begin
            bus_q <= BUS_WRITE;
          end else if (sel_read) begin
            bus_q <= BUS_READ;
          end
        end
        BUS_READ: begin
          acc_addr_q <= addr_s2_q;
          if (!sel_read) begin
            bus_q <= BUS_IDLE;
          end
        end
        BUS_WRITE: begin
          wr_data_q <= din_s2_q;
          if (!sel_write) begin
            bus_q <= BUS_IDLE;
          end
        end
      endcase
    end
  end

  assign rd_start = (bus_q == BUS_IDLE) && !sel_write && sel_read;
  assign wr_commit = (bus_q == BUS_WRITE) && !sel_write;
  assign tod_reg = is_tod_alarm(addr_s2_q);
  assign wd_reg = is_wd_reg(addr_s2_q);
  // a write decodes its captured address, the pins may move on release
  assign tod_acc = (tod_reg && rd_start) ||
                   (is_tod_alarm(acc_addr_q) && wr_commit);
  assign wd_acc = (wd_reg && rd_start) ||
                  (is_wd_reg(acc_addr_q) && wr_commit);

  // host-writable storage; flag bits of the command byte are ignored
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= CMD_CTRL_RESET;
      alarm_min_q <= ALARM_RESET;
      alarm_hour_q <= ALARM_RESET;
      alarm_day_q <= ALARM_RESET;
      wd_lo_q <= WD_RESET;
      wd_hi_q <= WD_RESET;
    end else if (wr_commit) begin
      unique case (acc_addr_q)
        ADDR_CMD: ctrl_q <= wr_data_q[7:2];
        ADDR_ALARM_MIN: alarm_min_q <= wr_data_q;
        ADDR_ALARM_HOUR: alarm_hour_q <= wr_data_q;
        ADDR_ALARM_DAY: alarm_day_q <= wr_data_q & DAY_ALARM_KEEP;
        ADDR_WD_LO: wd_lo_q <= wr_data_q;
        ADDR_WD_HI: wd_hi_q <= wr_data_q;
        default: ;
      endcase
    end
  end

  // read data registered while a read stands; unmapped bytes not driven
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data_q <= 8'h00;
      dq_oe <= 1'b0;
    end else begin
      unique case (addr_s2_q)
        ADDR_CMD: rd_data_q <= {ctrl_q, flag_q};
        ADDR_ALARM_MIN: rd_data_q <= alarm_min_q;
        ADDR_ALARM_HOUR: rd_data_q <= alarm_hour_q;
        ADDR_ALARM_DAY: rd_data_q <= alarm_day_q;
        ADDR_WD_LO: rd_data_q <= wd_lo_q;
        ADDR_WD_HI: rd_data_q <= wd_hi_q;
        default: rd_data_q <= 8'h00;
      endcase
      dq_oe <= sel_read && !oe_sync_q[1] &&
               (tod_reg || wd_reg || (addr_s2_q == ADDR_CMD));
    end
  end
  assign dq_out = rd_data_q;

  // time copy gate toward the visible time registers
  assign time_copy_strobe = tick_100hz && ctrl_q[BIT_TRANSFER_GATE-2];

  // alarm compare at each minute boundary; a set mask bit skips a field
  assign tod_match = minute_rollover &&
    (alarm_min_q[ALARM_MASK_BIT] ||
     (alarm_min_q[6:0] == cur_minutes[6:0])) &&
    (alarm_hour_q[ALARM_MASK_BIT] ||
     (alarm_hour_q[6:0] == cur_hours[6:0])) &&
    (alarm_day_q[ALARM_MASK_BIT] ||
     (alarm_day_q[2:0] == cur_day[2:0]));

  // watchdog countdown in BCD hundredths; zero value disables it
  assign wd_cnt_dec = {bcd_digit_dec(wd_cnt_q[15:12]) ^
                         ((wd_cnt_q[11:0] == 12'h000) ? 4'h0 :
                          (bcd_digit_dec(wd_cnt_q[15:12]) ^ wd_cnt_q[15:12])),
                       (wd_cnt_q[11:8] == 4'h0 && wd_cnt_q[7:0] != 8'h00) ?
                         wd_cnt_q[11:8] :
                         ((wd_cnt_q[7:0] == 8'h00) ?
                          bcd_digit_dec(wd_cnt_q[11:8]) : wd_cnt_q[11:8]),
                       (wd_cnt_q[3:0] == 4'h0) ?
                         bcd_digit_dec(wd_cnt_q[7:4]) : wd_cnt_q[7:4],
                       bcd_digit_dec(wd_cnt_q[3:0])};
  always_ff @(posedge clk) begin
    if (reset) begin
      wd_cnt_q <= WD_DISABLED;
      wd_reload_q <= 1'b0;
    end else begin
      wd_reload_q <= wd_acc;
      // zero is reached on the tick that leaves the last count
      if (wd_reload_q || (tick_100hz && wd_cnt_q == WD_LAST)) begin
        wd_cnt_q <= {wd_hi_q, wd_lo_q}; // restart, repeats without access
      end else if (tick_100hz && wd_cnt_q != WD_DISABLED) begin
        wd_cnt_q <= wd_cnt_dec;
      end
    end
  end

  // flag events; masks play no part in setting or clearing
  assign set_ev[SRC_TOD] = tod_match;
  assign set_ev[SRC_WD] = tick_100hz && !wd_reload_q &&
                          (wd_cnt_q == WD_LAST);
  assign clr_ev[SRC_TOD] = tod_acc;
  assign clr_ev[SRC_WD] = wd_acc || pulse_done[SRC_WD];
  assign mask[SRC_TOD] = ctrl_q[BIT_TOD_MASK-2];
  assign mask[SRC_WD] = ctrl_q[BIT_WD_MASK-2];

  // per-source flag, pulse timer and activity; set wins over clear
  generate
    for (genvar i = 0; i < 2; i++) begin : g_src
      always_ff @(posedge clk) begin
        if (reset) begin
          flag_q[i] <= 1'b0;
        end else if (set_ev[i]) begin
          flag_q[i] <= 1'b1;
        end else if (clr_ev[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
      assign pulse_start[i] = set_ev[i] && ctrl_q[BIT_PULSE_SELECT-2];
      irq_pulse_timer #(
        .CNT_W(PULSE_CNT_W),
        .LENGTH(PULSE_LEN)
      ) u_pulse (
        .clk(clk),
        .reset(reset),
        .start(pulse_start[i]),
        .active(pulse_act[i]),
        .done(pulse_done[i])
      );
      // level mode follows the flag, pulse mode the timer
      assign src_act[i] = !mask[i] && (ctrl_q[BIT_PULSE_SELECT-2] ?
                          pulse_act[i] : flag_q[i]);
    end
  endgenerate

  // line routing and polarity, applied live
  assign a_act = ctrl_q[BIT_ROUTE_SWAP-2] ? src_act[SRC_TOD] :
                 src_act[SRC_WD];
  assign b_act = ctrl_q[BIT_ROUTE_SWAP-2] ? src_act[SRC_WD] :
                 src_act[SRC_TOD];
  assign irq_line_a_n = !a_act;
  assign irq_line_b = b_act ? ctrl_q[BIT_B_POLARITY-2] :
                      !ctrl_q[BIT_B_POLARITY-2];

  a_copy_gated: assert property (@(posedge clk) disable iff (reset)
    !ctrl_q[BIT_TRANSFER_GATE-2] |-> !time_copy_strobe)
    else $error("time copied while transfer gate closed");
  a_route_tod_a: assert property (@(posedge clk) disable iff (reset)
    (ctrl_q[BIT_ROUTE_SWAP-2] && flag_q[SRC_TOD] && !mask[SRC_TOD] &&
     !ctrl_q[BIT_PULSE_SELECT-2]) |-> !irq_line_a_n)
    else $error("clock alarm missing on line A");
  a_route_tod_b: assert property (@(posedge clk) disable iff (reset)
    (!ctrl_q[BIT_ROUTE_SWAP-2] && flag_q[SRC_TOD] && !mask[SRC_TOD] &&
     !ctrl_q[BIT_PULSE_SELECT-2]) |->
    (irq_line_b == ctrl_q[BIT_B_POLARITY-2]))
    else $error("clock alarm missing on line B");
  a_wd_mask_quiet: assert property (@(posedge clk) disable iff (reset)
    (mask[SRC_WD] && mask[SRC_TOD]) |->
    (irq_line_a_n && irq_line_b != ctrl_q[BIT_B_POLARITY-2]))
    else $error("masked interrupt drives a line");
  a_tod_read_clr: assert property (@(posedge clk) disable iff (reset)
    (tod_reg && rd_start && !set_ev[SRC_TOD]) |=> !flag_q[SRC_TOD])
    else $error("clock match flag not cleared by alarm read");
  a_wd_access_clr: assert property (@(posedge clk) disable iff (reset)
    (((wd_reg && rd_start) || (is_wd_reg(acc_addr_q) && wr_commit)) &&
     !set_ev[SRC_WD]) |=>
    !flag_q[SRC_WD])
    else $error("watchdog flag not cleared by access");
  a_pulse_end_clr: assert property (@(posedge clk) disable iff (reset)
    (pulse_done[SRC_WD] && !set_ev[SRC_WD]) |=> !flag_q[SRC_WD])
    else $error("watchdog flag kept after pulse end");
  a_cmd_flags_hold: assert property (@(posedge clk) disable iff (reset)
    (wr_commit && acc_addr_q == ADDR_CMD && set_ev == 2'h0 &&
     clr_ev == 2'h0) |=> (flag_q == $past(flag_q)))
    else $error("command write changed a flag");
  a_wd_reload: assert property (@(posedge clk) disable iff (reset)
    wd_reload_q |=> (wd_cnt_q == $past({wd_hi_q, wd_lo_q})))
    else $error("watchdog not restarted after access");
endmodule : rtc_alarm_interrupt_control
`default_nettype wire

// [tb/host_bus_model.sv]
// host model: byte-wide asynchronous bus master for the alarm block
// assumes pins change 1 ns after a rising edge of the block clock
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
  input wire logic clk,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  output logic [5:0] addr,
  output logic [7:0] dq_in
);
  // each phase spans 4 edges so the 2-ff synchronisers see it
  localparam int PHASE = 4;
  initial begin
    ce_n = 1'b1;
    oe_n = 1'b1;
    we_n = 1'b1;
    addr = 6'h00;
    dq_in = 8'hA5;
  end
  // wait n edges, then step past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // write: data line released to its inverse as the strobes rise
  task automatic bus_write(input logic [5:0] a, input logic [7:0] d);
    ce_n = 1'b0;
    we_n = 1'b0;
    addr = a;
    dq_in = d;
    cyc(PHASE);
    ce_n = 1'b1;
    we_n = 1'b1;
    dq_in = ~d; // released data line does not keep its value
    cyc(PHASE);
  endtask : bus_write
  // read: answer sampled after the synchroniser delay
  task automatic bus_read(input logic [5:0] a, output logic [7:0] d,
                          output logic oe);
    ce_n = 1'b0;
    oe_n = 1'b0;
    addr = a;
    cyc(PHASE);
    d = dq_out;
    oe = dq_oe;
    ce_n = 1'b1;
    oe_n = 1'b1;
    cyc(PHASE);
  endtask : bus_read
endmodule : host_bus_model
`default_nettype wire

// [tb/tb_top.sv]
// testbench: register accesses, alarm matches, watchdog and line modes
// assumes a short interrupt pulse of 20 cycles for simulation
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtc_alarm_pkg::*;
  localparam int PL = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce_n, oe_n, we_n, dq_oe, tick_100hz, minute_rollover;
  logic time_copy_strobe, irq_line_a_n, irq_line_b;
  logic [5:0] addr;
  logic [7:0] dq_in, dq_out, cur_minutes, cur_hours, cur_day;
  int miscompares = 0;
  int total_checks = 0;
  int cycles_run = 0;
  int a_cnt = 0;
  int b_cnt = 0;
  int a0, b0;
  logic [7:0] am[7] = '{8'h80, 8'h15, 8'h15, 8'h15, 8'h15, 8'h15, 8'h15};
  logic [7:0] ah[7] = '{8'h80, 8'h80, 8'h80, 8'h08, 8'h08, 8'h08, 8'h08};
  logic [7:0] ad[7] = '{8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h03, 8'h03};
  logic [7:0] cm[7] = '{8'h10, 8'h14, 8'h15, 8'h15, 8'h15, 8'h15, 8'h15};
  logic [7:0] ch[7] = '{8'h00, 8'h00, 8'h00, 8'h09, 8'h08, 8'h08, 8'h08};
  logic [7:0] cd[7] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h02, 8'h03};
  logic [6:0] ex = 7'b1010101;
  rtc_alarm_interrupt_control #(.PULSE_LEN(20'd20))
    rtc_alarm_interrupt_control_i (.clk(clk), .reset(reset), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .addr(addr), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .tick_100hz(tick_100hz),
    .minute_rollover(minute_rollover), .cur_minutes(cur_minutes),
    .cur_hours(cur_hours), .cur_day(cur_day),
    .time_copy_strobe(time_copy_strobe), .irq_line_a_n(irq_line_a_n),
    .irq_line_b(irq_line_b));
  host_bus_model host_bus_model_i (.clk(clk), .dq_out(dq_out),
    .dq_oe(dq_oe), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(addr),
    .dq_in(dq_in));
  always #5 clk = ~clk;
  // cycle ceiling and low-cycle counters of both lines
  always @(posedge clk) begin
    cycles_run++;
    if (irq_line_a_n === 1'b0) a_cnt++;
    if (irq_line_b === 1'b0) b_cnt++;
    if (cycles_run == 6000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
               exp);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    host_bus_model_i.bus_write(a, d);
  endtask : wr
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic oe;
    host_bus_model_i.bus_read(a, d, oe);
    chk({7'h00, oe}, 8'h01, "read enable");
    chk(d, exp, "read data");
  endtask : rdchk
  task automatic lines(input logic [1:0] exp);
    chk({6'h00, irq_line_a_n, irq_line_b}, {6'h00, exp}, "irq lines");
  endtask : lines
  // one-cycle strobes of the time base
  task automatic tick();
    tick_100hz = 1'b1;
    host_bus_model_i.cyc(1);
    tick_100hz = 1'b0;
    host_bus_model_i.cyc(1);
  endtask : tick
  task automatic roll();
    minute_rollover = 1'b1;
    host_bus_model_i.cyc(1);
    minute_rollover = 1'b0;
    host_bus_model_i.cyc(1);
  endtask : roll
  initial begin
    logic [7:0] d;
    logic oe;
    tick_100hz = 1'b0;
    minute_rollover = 1'b0;
    {cur_minutes, cur_hours, cur_day} = 24'h000001;
    host_bus_model_i.cyc(4);
    reset = 1'b0;
    host_bus_model_i.cyc(2);
    // reset state, read-only flags, unmapped address
    lines(2'b11);
    rdchk(ADDR_CMD, 8'h00);
    wr(ADDR_CMD, 8'hFF);
    rdchk(ADDR_CMD, 8'hFC);
    host_bus_model_i.bus_read(6'h3F, d, oe);
    chk({7'h00, oe}, 8'h00, "unmapped enable");
    // transfer gate on then off
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_CMD, i == 0 ? 8'h80 : 8'h00);
      tick_100hz = 1'b1;
      #1;
      chk({7'h00, time_copy_strobe}, i == 0 ? 8'h01 : 8'h00, "copy");
      host_bus_model_i.cyc(1);
      tick_100hz = 1'b0;
    end
    wr(ADDR_ALARM_DAY, 8'hFF);
    rdchk(ADDR_ALARM_DAY, 8'h87);
    // alarm compare table with the clock interrupt masked
    wr(ADDR_CMD, 8'h04);
    for (int i = 0; i < 7; i++) begin
      wr(ADDR_ALARM_MIN, am[i]);
      wr(ADDR_ALARM_HOUR, ah[i]);
      wr(ADDR_ALARM_DAY, ad[i]);
      {cur_minutes, cur_hours, cur_day} = {cm[i], ch[i], cd[i]};
      roll();
      lines(2'b11);
      rdchk(ADDR_CMD, {7'b0000010, ex[i]});
    end
    // clock alarm flag set: unmask, route, polarity, clear by read
    wr(ADDR_CMD, 8'h00);
    lines(2'b10);
    wr(ADDR_CMD, 8'h40);
    lines(2'b01);
    wr(ADDR_CMD, 8'h20);
    lines(2'b11);
    rdchk(ADDR_ALARM_MIN, 8'h15);
    lines(2'b10);
    rdchk(ADDR_CMD, 8'h20);
    // watchdog in level mode on line A
    wr(ADDR_CMD, 8'h00);
    wr(ADDR_WD_LO, 8'h03);
    wr(ADDR_WD_HI, 8'h00);
    tick();
    tick();
    lines(2'b11);
    tick();
    lines(2'b01);
    wr(ADDR_CMD, 8'h08);
    lines(2'b11);
    rdchk(ADDR_CMD, 8'h0A);
    rdchk(ADDR_WD_LO, 8'h03);
    rdchk(ADDR_CMD, 8'h08);
    // pulse mode: watchdog on line A, then clock alarm on line B
    wr(ADDR_CMD, 8'h10);
    a0 = a_cnt;
    repeat (3) tick();
    host_bus_model_i.cyc(40);
    chk(8'(a_cnt - a0), 8'(PL), "pulse a");
    rdchk(ADDR_CMD, 8'h10);
    wr(ADDR_ALARM_MIN, 8'h80);
    wr(ADDR_ALARM_HOUR, 8'h80);
    wr(ADDR_ALARM_DAY, 8'h80);
    b0 = b_cnt;
    roll();
    host_bus_model_i.cyc(40);
    chk(8'(b_cnt - b0), 8'(PL), "pulse b");
    rdchk(ADDR_CMD, 8'h11);
    // level mode swapped, line B active high: watchdog now on line B
    wr(ADDR_CMD, 8'h60);
    lines(2'b00);
    repeat (3) tick();
    lines(2'b01);
    rdchk(ADDR_WD_HI, 8'h00);
    lines(2'b00);
    // reset in mid-run clears control bits, flags and lines
    reset = 1'b1;
    host_bus_model_i.cyc(2);
    reset = 1'b0;
    host_bus_model_i.cyc(2);
    lines(2'b11);
    rdchk(ADDR_CMD, 8'h00);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
